// >>> verilog/fp_exc_pkg.sv
// Purpose: shared constants and helpers for float exception reporting
// Assumes: 25 MHz system clock, classic Wishbone register access
// Notes:   offsets are byte addresses of aligned 32-bit words
package fp_exc_pkg;
    // ========================================================
    // timing
    localparam int SAVE_PULSE_CYC = 2;
    // ========================================================
    // widths and vectors
    localparam int FLAG_W = 6;
    localparam int ELEM_N = 4;
    localparam int IRQ_W  = 3;
    localparam logic [7:0] VEC_FLOAT_ERR  = 8'h10;
    localparam logic [7:0] VEC_SIMD_FAULT = 8'h13;
    // ========================================================
    // register offsets
    localparam logic [7:0] OFS_CTRL0    = 8'h00;
    localparam logic [7:0] OFS_SCALAR   = 8'h04;
    localparam logic [7:0] OFS_SIMDCS   = 8'h08;
    localparam logic [7:0] OFS_IRQSTAT  = 8'h0C;
    localparam logic [7:0] OFS_IRQMASK  = 8'h10;
    localparam logic [7:0] OFS_STATE    = 8'h14;
    // ========================================================
    // field positions
    localparam int NATIVE_SEL_BIT = 5;
    localparam int SC_FLAG_LSB    = 0;
    localparam int SC_MASK_LSB    = 8;
    localparam int SC_PEND_BIT    = 15;
    localparam int SD_FLAG_LSB    = 0;
    localparam int SD_MASK_LSB    = 7;
    localparam int IRQ_SCALAR     = 0;
    localparam int IRQ_SIMD       = 1;
    localparam int IRQ_SAVE       = 2;
    // ========================================================
    // reset values
    localparam logic              CTRL0_RST    = 1'b0;
    localparam logic [FLAG_W-1:0] SC_MASK_RST  = 6'h3F;
    localparam logic [FLAG_W-1:0] SD_MASK_RST  = 6'h3F;
    localparam logic [IRQ_W-1:0]  IRQ_MASK_RST = 3'h0;

    // flags whose mask bit is clear
    function automatic logic [FLAG_W-1:0] unmasked(
        input logic [FLAG_W-1:0] flags,
        input logic [FLAG_W-1:0] masks);
        return flags & ~masks;
    endfunction : unmasked

    // write-one-to-clear with set winning over clear
    function automatic logic [FLAG_W-1:0] w1c(
        input logic [FLAG_W-1:0] cur,
        input logic [FLAG_W-1:0] clr,
        input logic [FLAG_W-1:0] set);
        return (cur & ~clr) | set;
    endfunction : w1c
endpackage : fp_exc_pkg

// >>> verilog/simd_exc_if.sv
// Purpose: link between the reporting top and the SIMD exception unit
// Assumes: one clock domain
// Notes:   unit outputs are registered one-cycle pulses
`timescale 1ns/1ps
interface simd_exc_if;
    import fp_exc_pkg::*;
    logic                     opValid;   // SIMD op completes
    logic                     opRecip;   // approximation op
    logic [ELEM_N-1:0]        elemValid; // active elements
    logic [ELEM_N*FLAG_W-1:0] elemFlags; // per-element flags
    logic [FLAG_W-1:0]        masks;     // current masks
    logic [FLAG_W-1:0]        setFlags;  // sticky flags to set
    logic                     fault;     // raise vector 19
    logic                     useDefault;// deliver default result

    modport core (output opValid, opRecip, elemValid, elemFlags,
                  masks, input setFlags, fault, useDefault);
    modport unit (input opValid, opRecip, elemValid, elemFlags,
                  masks, output setFlags, fault, useDefault);
endinterface : simd_exc_if

// >>> verilog/simd_exc_unit.sv
// Purpose: SIMD float exception evaluation, masked or faulting
// Assumes: flags of an op arrive with opValid in one cycle
// Notes:   results appear one cycle after opValid
`timescale 1ns/1ps
module simd_exc_unit
    import fp_exc_pkg::*;
(
    input  wire logic clk_sys, // system clock
    input  wire logic srst,    // sync reset, high
    simd_exc_if.unit  sx       // link to top
);
    logic [FLAG_W-1:0] orFlags;
    logic [FLAG_W-1:0] setFf;
    logic              faultFf;
    logic              defFf;

    // ========================================================
    // combine elements
    // or of elements
    always_comb begin
        orFlags = '0;
        for (int i = 0; i < ELEM_N; i++) begin
            if (sx.elemValid[i]) begin
                orFlags = orFlags | sx.elemFlags[i*FLAG_W +: FLAG_W];
            end
        end
    end

    // ========================================================
    // per-op decision, signalled by the op itself
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            setFf   <= '0;
            faultFf <= 1'b0;
            defFf   <= 1'b0;
        end else begin
            setFf   <= '0;
            faultFf <= 1'b0;
            defFf   <= 1'b0;
            if (sx.opValid && !sx.opRecip && orFlags != '0) begin
                if (unmasked(orFlags, sx.masks) != '0) begin
                    faultFf <= 1'b1;
                end else begin
                    setFf <= orFlags;
                    defFf <= 1'b1;
                end
            end
        end
    end

    assign sx.setFlags   = setFf;
    assign sx.fault      = faultFf;
    assign sx.useDefault = defFf;
endmodule : simd_exc_unit

// >>> verilog/fp_exception_reporting.sv
// Purpose: float exception recording and trap delivery
// Assumes: core inputs in clk_sys
// Notes:   classic Wishbone, one wait state
//
// Operation
// - unmasked scalar exception: pending, error output
// - waiting op with pending is held, takes vector 16 natively
// - no-wait ops run, exception stays pending except on a save
// - control bit 5 selects native mode
// - native: 16 before next waiting op
// - error output in both modes alike
// - native: no-wait ops never cause 16
// - save while pending pulses error output
// - native delivery is internal
// - multiprocessor reports natively only
// - masked SIMD: default, sticky, silent
// - sticky flags do not name the element
// - unmasked SIMD faults through 19
// - approximations never raise SIMD faults
// - sticky flags are or of elements
// - SIMD faults come from the op itself
// - set sticky flag never faults later
//
// The implementer's own choices: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module fp_exception_reporting
    import fp_exc_pkg::*;
(
    input  wire logic                     clk_sys,     // system clock
    input  wire logic                     srst,        // sync reset
    // wishbone slave
    input  wire logic                     wb_cyc_i,    // cycle
    input  wire logic                     wb_stb_i,    // strobe
    input  wire logic                     wb_we_i,     // write
    input  wire logic [7:0]               wb_adr_i,    // byte address
    input  wire logic [3:0]               wb_sel_i,    // byte lanes
    input  wire logic [31:0]              wb_dat_i,    // write data
    output logic      [31:0]              wb_dat_o,    // read data
    output logic                          wb_ack_o,    // acknowledge
    // scalar unit
    input  wire logic                     fpExcValid,  // exception event
    input  wire logic [FLAG_W-1:0]        fpExcFlags,  // raised flags
    input  wire logic                     fpInit,      // reinit state
    // instruction issue
    input  wire logic                     instrValid,  // op presented
    input  wire logic                     instrWait,   // waiting type
    input  wire logic                     instrSave,   // no-wait save
    output logic                          instrAccept, // op may run
    output logic                          trapTake,    // vector taken
    output logic      [7:0]               trapVector,  // vector number
    // SIMD unit
    input  wire logic                     simdValid,   // op completes
    input  wire logic                     simdRecip,   // approx op
    input  wire logic [ELEM_N-1:0]        simdElemValid,// elements
    input  wire logic [ELEM_N*FLAG_W-1:0] simdElemFlags,// flags
    output logic                          simdDefault, // default result
    // system
    input  wire logic                     mpStrap,     // multi-cpu pin
    output logic                          floatFaultOut,// error output
    output logic                          legacyFloatIrqLine,// legacy irq
    output logic                          irqOut       // interrupt
);
    // ========================================================
    // declarations
    simd_exc_if sx ();

    logic              ackFf;
    logic [31:0]       rdataFf;
    logic              nativeSelFf;
    logic [FLAG_W-1:0] scFlagsFf;
    logic [FLAG_W-1:0] scMasksFf;
    logic [FLAG_W-1:0] sdFlagsFf;
    logic [FLAG_W-1:0] sdMasksFf;
    logic [IRQ_W-1:0]  irqStatFf;
    logic [IRQ_W-1:0]  irqMaskFf;
    logic [2:0]        mpSyncFf;
    logic              mpStableFf;
    logic [1:0]        pulseCntFf;
    logic              faultOutFf;
    logic              trapFf;
    logic [7:0]        vecFf;
    logic              pendPrevFf;

    logic              wbReq;
    logic              wrStb;
    logic [31:0]       wrBits;
    logic              nativeEff;
    logic              pending;
    logic              fpTrap;
    logic              saveHit;
    logic [FLAG_W-1:0] scSet;
    logic [FLAG_W-1:0] scClr;
    logic [FLAG_W-1:0] sdClr;
    logic [IRQ_W-1:0]  irqSet;
    logic [IRQ_W-1:0]  irqClr;

    // ========================================================
    // bus decode
    // one request per ack
    assign wbReq = wb_cyc_i && wb_stb_i && !ackFf;
    assign wrStb = wbReq && wb_we_i;

    // data bits gated by byte lanes
    always_comb begin
        wrBits = '0;
        for (int b = 0; b < 4; b++) begin
            if (wb_sel_i[b]) begin
                wrBits[b*8 +: 8] = wb_dat_i[b*8 +: 8];
            end
        end
    end

    // ack one cycle after request
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            ackFf <= 1'b0;
        end else begin
            ackFf <= wbReq;
        end
    end

    // read mux, unmapped offsets read zero
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            rdataFf <= '0;
        end else if (wbReq && !wb_we_i) begin
            rdataFf <= '0;
            unique case (wb_adr_i)
                OFS_CTRL0: begin
                    rdataFf[NATIVE_SEL_BIT] <= nativeSelFf;
                end
                OFS_SCALAR: begin
                    rdataFf[SC_FLAG_LSB +: FLAG_W] <= scFlagsFf;
                    rdataFf[SC_MASK_LSB +: FLAG_W] <= scMasksFf;
                    rdataFf[SC_PEND_BIT]           <= pending;
                end
                OFS_SIMDCS: begin
                    rdataFf[SD_FLAG_LSB +: FLAG_W] <= sdFlagsFf;
                    rdataFf[SD_MASK_LSB +: FLAG_W] <= sdMasksFf;
                end
                OFS_IRQSTAT: begin
                    rdataFf[IRQ_W-1:0] <= irqStatFf;
                end
                OFS_IRQMASK: begin
                    rdataFf[IRQ_W-1:0] <= irqMaskFf;
                end
                OFS_STATE: begin
                    rdataFf[0] <= nativeEff;
                    rdataFf[1] <= mpStableFf;
                    rdataFf[2] <= faultOutFf;
                end
                default: begin
                    rdataFf <= '0;
                end
            endcase
        end
    end

    assign wb_ack_o = ackFf;
    assign wb_dat_o = rdataFf;

    // ========================================================
    // multiprocessor strap, three-stage filter
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            mpSyncFf <= '0;
        end else begin
            mpSyncFf <= {mpSyncFf[1:0], mpStrap};
        end
    end

    // level taken when stages 1 and 2 agree
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            mpStableFf <= 1'b0;
        end else if (mpSyncFf[1] == mpSyncFf[2]) begin
            mpStableFf <= mpSyncFf[2];
        end
    end

    // ========================================================
    // mode control
    // native select bit
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            nativeSelFf <= CTRL0_RST;
        end else if (wrStb && wb_adr_i == OFS_CTRL0) begin
            nativeSelFf <= wrBits[NATIVE_SEL_BIT];
        end
    end

    assign nativeEff = nativeSelFf || mpStableFf;

    // ========================================================
    // scalar exception record
    assign scSet = fpExcValid ? fpExcFlags : '0;
    assign scClr = (wrStb && wb_adr_i == OFS_SCALAR) ?
                   wrBits[SC_FLAG_LSB +: FLAG_W] : '0;

    // pending is any unmasked recorded flag
    assign pending = unmasked(scFlagsFf, scMasksFf) != '0;

    // no-wait save of a pending state
    assign saveHit = instrValid && instrSave && pending;

    // flags held until cleared, reinit or save
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            scFlagsFf <= '0;
        end else if (fpInit || saveHit) begin
            scFlagsFf <= scSet;
        end else begin
            scFlagsFf <= w1c(scFlagsFf, scClr, scSet);
        end
    end

    // scalar exception masks
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            scMasksFf <= SC_MASK_RST;
        end else if (wrStb && wb_adr_i == OFS_SCALAR) begin
            scMasksFf <= wrBits[SC_MASK_LSB +: FLAG_W];
        end
    end

    // ========================================================
    // instruction gating
    // waiting op meets pending
    // no external path in the trap
    assign fpTrap = instrValid && instrWait && !instrSave &&
                    pending && nativeEff;

    // legacy mode holds a waiting op until the handler clears
    // no-wait ops always run
    always_comb begin
        instrAccept = 1'b0;
        if (instrValid) begin
            if (instrSave || !instrWait) begin
                instrAccept = 1'b1;
            end else if (!pending) begin
                instrAccept = 1'b1;
            end
        end
    end

    // vector delivery, SIMD fault wins a shared cycle
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            trapFf <= 1'b0;
            vecFf  <= '0;
        end else begin
            trapFf <= fpTrap || sx.fault;
            if (sx.fault) begin
                vecFf <= VEC_SIMD_FAULT;
            end else if (fpTrap) begin
                vecFf <= VEC_FLOAT_ERR;
            end
        end
    end

    assign trapTake   = trapFf;
    assign trapVector = vecFf;

    // ========================================================
    // error output
    // stretch a pulse on save
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            pulseCntFf <= '0;
        end else if (saveHit) begin
            pulseCntFf <= 2'(SAVE_PULSE_CYC);
        end else if (pulseCntFf != '0) begin
            pulseCntFf <= pulseCntFf - 2'h1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            faultOutFf <= 1'b0;
        end else begin
            faultOutFf <= pending || saveHit || pulseCntFf > 2'h1;
        end
    end

    assign floatFaultOut = faultOutFf;

    // legacy line only outside native mode
    assign legacyFloatIrqLine = faultOutFf && !nativeEff;

    // ========================================================
    // SIMD path
    assign sx.opValid   = simdValid;
    assign sx.opRecip   = simdRecip;
    assign sx.elemValid = simdElemValid;
    assign sx.elemFlags = simdElemFlags;
    assign sx.masks     = sdMasksFf;

    simd_exc_unit uSimd (
        .clk_sys (clk_sys),
        .srst    (srst),
        .sx      (sx.unit)
    );

    assign sdClr = (wrStb && wb_adr_i == OFS_SIMDCS) ?
                   wrBits[SD_FLAG_LSB +: FLAG_W] : '0;

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            sdFlagsFf <= '0;
        end else begin
            sdFlagsFf <= w1c(sdFlagsFf, sdClr, sx.setFlags);
        end
    end

    // mask writes never raise a fault
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            sdMasksFf <= SD_MASK_RST;
        end else if (wrStb && wb_adr_i == OFS_SIMDCS) begin
            sdMasksFf <= wrBits[SD_MASK_LSB +: FLAG_W];
        end
    end

    // default result marker, one cycle
    assign simdDefault = sx.useDefault;

    // ========================================================
    // interrupt status and mask
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            pendPrevFf <= 1'b0;
        end else begin
            pendPrevFf <= pending;
        end
    end

    always_comb begin
        irqSet             = '0;
        irqSet[IRQ_SCALAR] = pending && !pendPrevFf;
        irqSet[IRQ_SIMD]   = sx.fault;
        irqSet[IRQ_SAVE]   = saveHit;
    end

    assign irqClr = (wrStb && wb_adr_i == OFS_IRQSTAT) ?
                    wrBits[IRQ_W-1:0] : '0;

    // sticky events, set wins over clear
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            irqStatFf <= '0;
        end else begin
            irqStatFf <= (irqStatFf & ~irqClr) | irqSet;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            irqMaskFf <= IRQ_MASK_RST;
        end else if (wrStb && wb_adr_i == OFS_IRQMASK) begin
            irqMaskFf <= wrBits[IRQ_W-1:0];
        end
    end

    // level interrupt
    assign irqOut = (irqStatFf & irqMaskFf) != '0;
endmodule : fp_exception_reporting

// >>> test/fp_exception_reporting_chk.sv
// Purpose: port assertions
// Assumes: one clock, srst high
// Notes:   bound to the top
`timescale 1ns/1ps
module fp_exception_reporting_chk
    import fp_exc_pkg::*;
(
    input wire logic                     clk_sys,       // clock
    input wire logic                     srst,          // reset
    input wire logic                     wb_cyc_i,      // cycle
    input wire logic                     wb_stb_i,      // strobe
    input wire logic                     wb_ack_o,      // acknowledge
    input wire logic                     fpExcValid,    // scalar event
    input wire logic                     instrValid,    // op presented
    input wire logic                     instrWait,     // waiting op
    input wire logic                     instrSave,     // save op
    input wire logic                     instrAccept,   // op may run
    input wire logic                     trapTake,      // vector taken
    input wire logic [7:0]               trapVector,    // vector
    input wire logic                     simdValid,     // simd op
    input wire logic                     simdRecip,     // approx op
    input wire logic [ELEM_N*FLAG_W-1:0] simdElemFlags, // elem flags
    input wire logic                     simdDefault,   // default used
    input wire logic                     floatFaultOut, // error output
    input wire logic                     legacyFloatIrqLine // legacy
);
    // ========================================================
    // properties
    default clocking @(posedge clk_sys); endclocking
    default disable iff (srst);
    sequence busTake;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence saveTail;
        floatFaultOut ##[1:3] !floatFaultOut;
    endsequence
    bus_answer_a: assert property (busTake |=> wb_ack_o)
        else $error("ack late");
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack too long");
    nowait_runs_a: assert property (instrValid && !instrWait
        |-> instrAccept) else $error("no-wait op held");
    nowait_notrap_a: assert property (instrValid && !instrWait
        |=> !(trapTake && trapVector == VEC_FLOAT_ERR))
        else $error("no-wait op trapped");
    trap_cause_a: assert property (trapTake &&
        trapVector == VEC_FLOAT_ERR |-> $past(instrValid &&
        instrWait && !instrAccept && floatFaultOut))
        else $error("stray float trap");
    legacy_follow_a: assert property (legacyFloatIrqLine
        |-> floatFaultOut) else $error("stray legacy line");
    fault_cause_a: assert property ($rose(floatFaultOut)
        |-> $past(fpExcValid) || $past(fpExcValid, 2))
        else $error("stray error output");
    save_pulse_a: assert property (instrValid && instrSave &&
        floatFaultOut |=> saveTail) else $error("bad save pulse");
    simd_fault_a: assert property (trapTake &&
        trapVector == VEC_SIMD_FAULT |->
        $past(simdValid && !simdRecip, 2)) else $error("stray fault");
    recip_quiet_a: assert property (simdValid && simdRecip
        |=> !simdDefault ##1 !(trapTake &&
        trapVector == VEC_SIMD_FAULT)) else $error("approx op raised");
    default_cause_a: assert property (simdDefault |->
        $past(simdValid && |simdElemFlags) && !(trapTake &&
        trapVector == VEC_SIMD_FAULT)) else $error("stray default");
endmodule : fp_exception_reporting_chk
bind fp_exception_reporting fp_exception_reporting_chk i_chk (.*);

// >>> test/fp_irq_ctrl_model.sv
// Purpose: interrupt controller on the legacy line
// Assumes: software disables it natively
// Notes:   one request flop
`timescale 1ns/1ps
module fp_irq_ctrl_model (
    input  wire logic clk_sys,    // clock
    input  wire logic srst,       // reset
    input  wire logic lineIn,     // legacy error line
    input  wire logic nativeMode, // software runs native
    output logic      irqReq      // request toward the core
);
    // ========================================================
    // request latch
    logic reqLatch_ff; // latched request
    always_ff @(posedge clk_sys) begin
        reqLatch_ff <= srst ? 1'b0 : lineIn && !nativeMode;
    end
    assign irqReq = reqLatch_ff; // registered request
endmodule : fp_irq_ctrl_model

// >>> test/fp_exception_reporting_tb.sv
// Purpose: self-checking bench
// Assumes: 25 MHz clock
// Notes:   fixed seed
`timescale 1ns/1ps
module fp_exception_reporting_tb;
    import fp_exc_pkg::*;
    logic clk_sys, srst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
    logic [7:0] wb_adr_i, trapVector;
    logic [3:0] wb_sel_i, simdElemValid;
    logic [31:0] wb_dat_i, wb_dat_o;
    logic fpExcValid, fpInit, instrValid, instrWait, instrSave;
    logic instrAccept, trapTake, simdValid, simdRecip, simdDefault;
    logic [FLAG_W-1:0] fpExcFlags;
    logic [ELEM_N*FLAG_W-1:0] simdElemFlags;
    logic mpStrap, floatFaultOut, legacyFloatIrqLine, irqOut;
    logic nativeMode, irqReq;
    int bad_count, comparisons;
    fp_exception_reporting i_fp_exception_reporting (.*);
    fp_irq_ctrl_model i_fp_irq_ctrl_model (.clk_sys, .srst,
        .lineIn(legacyFloatIrqLine), .nativeMode, .irqReq);
    // ========================================================
    // clock and watchdog
    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end
    initial begin
        repeat (20000) @(posedge clk_sys);
        bad_count++;
        conclude();
    end
    task automatic chk32(input logic [31:0] g, input logic [31:0] e);
        comparisons++;
        if (g !== e) begin
            bad_count++;
            $display("unexpected at %0t: word %h not %h", $time, g, e);
        end
    endtask : chk32
    task automatic chkBit(input logic g, input logic e);
        comparisons++;
        if (g !== e) begin
            bad_count++;
            $display("unexpected at %0t: bit %b not %b", $time, g, e);
        end
    endtask : chkBit
    // one classic bus cycle, held until ack
    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q);
        @(posedge clk_sys);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, w, a, d};
        do @(posedge clk_sys);
        while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        {wb_cyc_i, wb_stb_i} <= 2'b00;
    endtask : wb
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        wb(1'b1, a, d, q);
    endtask : wr
    task automatic rdChk(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        wb(1'b0, a, 32'h0, q);
        chk32(q, e);
    endtask : rdChk
    // present one op, return accept and trap
    task automatic op(input logic w, input logic s, output logic acc,
                      output logic tr, output logic [7:0] v);
        @(posedge clk_sys);
        {instrValid, instrWait, instrSave} <= {1'b1, w, s};
        @(posedge clk_sys);
        acc = instrAccept;
        instrValid <= 1'b0;
        @(posedge clk_sys);
        tr = trapTake;
        v = trapVector;
    endtask : op
    task automatic exc(input logic [5:0] f);
        @(posedge clk_sys);
        {fpExcValid, fpExcFlags} <= {1'b1, f};
        @(posedge clk_sys);
        fpExcValid <= 1'b0;
        repeat (3) @(posedge clk_sys);
    endtask : exc
    task automatic simd(input logic r, input logic [3:0] ev,
                        input logic [23:0] ef, output logic tr,
                        output logic df, output logic [7:0] v);
        @(posedge clk_sys);
        {simdValid, simdRecip, simdElemValid, simdElemFlags} <= {1'b1, r, ev, ef};
        @(posedge clk_sys);
        simdValid <= 1'b0;
        @(posedge clk_sys);
        df = simdDefault;
        // trap leaves one cycle after the unit's fault
        @(posedge clk_sys);
        tr = trapTake;
        v = trapVector;
    endtask : simd
    function automatic logic [5:0] orFlags(input logic [3:0] ev,
                                           input logic [23:0] ef);
        logic [5:0] r;
        r = 6'h00;
        for (int i = 0; i < ELEM_N; i++)
            if (ev[i]) r |= ef[6*i +: 6];
        return r;
    endfunction : orFlags
    task automatic conclude();
        $display("comparisons %0d bad_count %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : conclude
    // ========================================================
    // main sequence
    initial begin
        logic a, t, d, r;
        logic [7:0] v;
        logic [5:0] m, f, o, u;
        logic [3:0] ev;
        logic [23:0] ef;
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} = '0;
        {fpExcValid, fpExcFlags, fpInit, instrValid, instrWait} = '0;
        {instrSave, simdValid, simdRecip, simdElemValid} = '0;
        {simdElemFlags, mpStrap, nativeMode} = '0;
        wb_sel_i = 4'hF;
        srst = 1'b1;
        void'($urandom(32'h7251));
        repeat (16) @(posedge clk_sys);
        srst <= 1'b0;
        rdChk(OFS_CTRL0, 32'h0);
        rdChk(OFS_SCALAR, 32'h3F00);
        rdChk(OFS_SIMDCS, 32'h1F80);
        rdChk(OFS_IRQMASK, 32'h0);
        rdChk(8'h1C, 32'h0);
        wr(OFS_IRQMASK, 32'h7);
        wr(OFS_SCALAR, 32'h0);
        f = 6'($urandom_range(1, 63));
        exc(f);
        chkBit(floatFaultOut, 1'b1);
        chkBit(legacyFloatIrqLine, 1'b1);
        chkBit(irqReq, 1'b1);
        chkBit(irqOut, 1'b1);
        op(1'b0, 1'b0, a, t, v);
        chkBit(a & ~t, 1'b1);
        op(1'b1, 1'b0, a, t, v);
        chkBit(a | t, 1'b0);
        rdChk(OFS_SCALAR, {16'h0, 10'h200, f});
        wr(OFS_IRQSTAT, 32'h1);
        repeat (2) @(posedge clk_sys);
        chkBit(irqOut, 1'b0);
        op(1'b0, 1'b1, a, t, v);
        repeat (4) @(posedge clk_sys);
        chkBit(a & ~floatFaultOut, 1'b1);
        rdChk(OFS_IRQSTAT, 32'h4);
        wr(OFS_IRQSTAT, 32'h7);
        wr(OFS_CTRL0, 32'h20);
        nativeMode <= 1'b1;
        rdChk(OFS_STATE, 32'h1);
        exc(6'($urandom_range(1, 63)));
        chkBit(floatFaultOut & ~legacyFloatIrqLine, 1'b1);
        chkBit(irqReq, 1'b0);
        op(1'b0, 1'b0, a, t, v);
        chkBit(a & ~t, 1'b1);
        op(1'b1, 1'b0, a, t, v);
        chk32({a, t, v}, {2'b01, VEC_FLOAT_ERR});
        op(1'b0, 1'b1, a, t, v);
        chkBit(a & ~t, 1'b1);
        exc(6'h01);
        @(posedge clk_sys);
        fpInit <= 1'b1;
        @(posedge clk_sys);
        fpInit <= 1'b0;
        repeat (3) @(posedge clk_sys);
        chkBit(floatFaultOut, 1'b0);
        for (int i = 0; i < 24; i++) begin
            m = (i < 4) ? {6{i[0]}} : 6'($urandom);
            r = (i % 6 == 5);
            ev = 4'($urandom);
            ef = 24'($urandom);
            wr(OFS_SIMDCS, {19'h0, m, 7'h3F});
            simd(r, ev, ef, t, d, v);
            o = r ? 6'h00 : orFlags(ev, ef);
            u = o & ~m;
            chkBit(t, |u);
            chkBit(d, |o && !(|u));
            if (t) chk32({24'h0, v}, {24'h0, VEC_SIMD_FAULT});
            rdChk(OFS_SIMDCS, {19'h0, m, 1'b0, |u ? 6'h0 : o});
        end
        wr(OFS_SIMDCS, 32'h1FBF);
        simd(1'b0, 4'h1, 24'h1, t, d, v);
        wr(OFS_IRQSTAT, 32'h7);
        wr(OFS_SIMDCS, 32'h0);
        rdChk(OFS_IRQSTAT, 32'h0);
        wr(OFS_CTRL0, 32'h0);
        mpStrap <= 1'b1;
        repeat (5) @(posedge clk_sys);
        rdChk(OFS_STATE, 32'h3);
        conclude();
    end
endmodule : fp_exception_reporting_tb
